// ---- design/iecm_top.sv ----
// iecm_top: input conditioning, counters, analog/temperature status, report trigger
// assumes adc and temperature samples arrive with one-cycle valid strobes
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/10ps
module iecm_top
  import iecm_pkg::*;
#(
  parameter int TICK_CYC = SEC_CYC
) (
  mclk,
  nrst,
  di_pin,
  ai_val,
  ai_vld,
  t_val,
  t_fault,
  t_vld,
  ts_time,
  ts_vld,
  rpt_ack,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  rpt_req,
  rpt_cause,
  evt_stamp,
  ts_req,
  pair_fault
);
  input wire logic mclk;
  input wire logic nrst;
  input wire logic [NUM_DI-1:0] di_pin;
  input wire logic [NUM_AI*VAL_W-1:0] ai_val;
  input wire logic ai_vld;
  input wire logic [NUM_TI*VAL_W-1:0] t_val;
  input wire logic [NUM_TI-1:0] t_fault;
  input wire logic t_vld;
  input wire logic [RTC_W-1:0] ts_time;
  input wire logic ts_vld;
  input wire logic rpt_ack;
  input wire logic [7:0] reg_addr;
  input wire logic [31:0] reg_wdata;
  input wire logic reg_wr;
  input wire logic reg_rd;
  output logic [31:0] reg_rdata;
  output logic rpt_req;
  output logic [RC_W-1:0] rpt_cause;
  output logic [RTC_W-1:0] evt_stamp;
  output logic ts_req;
  output logic [NUM_DI/2-1:0] pair_fault;

  localparam int NAS = NUM_AI * 4;

  // ************************************************************
  // configuration registers
  // ************************************************************
  logic [NUM_DI-1:0] inv_r;
  logic [NAS-1:0] ainv_r;
  logic [15:0] dly_r;
  logic [NUM_DI/2-1:0] pair_en_r;
  logic [15:0] travel_r;
  logic [7:0] flut_win_r;
  logic [7:0] flut_max_r;
  logic [NUM_DI-1:0] cmode_r;
  logic [1:0] tres_r;
  logic [RTC_W-1:0] csync_at_r;
  logic [15:0] csync_iv_r;
  logic [NUM_AI-1:0] amode_r;
  logic [VAL_W-1:0] lim1_r;
  logic [VAL_W-1:0] lim2_r;
  logic [VAL_W-1:0] delta_r;
  logic [15:0] acyc_r;
  logic [VAL_W-1:0] tlim1_r;
  logic [VAL_W-1:0] tlim2_r;
  logic [15:0] tsync_iv_r;
  logic [RTC_W-1:0] rtc_r;
  logic cmd_cgi;
  logic cmd_gi;
  logic cmd_crst;

  assign cmd_cgi = reg_wr && reg_addr == A_CMD && reg_wdata[CMD_CGI];
  assign cmd_gi = reg_wr && reg_addr == A_CMD && reg_wdata[CMD_GI];
  assign cmd_crst = reg_wr && reg_addr == A_CMD && reg_wdata[CMD_CRST];

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      inv_r <= '0;
      ainv_r <= '0;
      dly_r <= '0;
      pair_en_r <= '0;
      travel_r <= 16'h000a;
      flut_win_r <= 8'h0a;
      flut_max_r <= 8'h00;
      cmode_r <= '0;
      tres_r <= 2'h0;
      csync_at_r <= '0;
      csync_iv_r <= 16'h0000;
      amode_r <= '0;
      lim1_r <= '1;
      lim2_r <= '1;
      delta_r <= '1;
      acyc_r <= 16'h0000;
      tlim1_r <= '1;
      tlim2_r <= '1;
      tsync_iv_r <= 16'h0000;
    end else if (reg_wr) begin
      unique case (reg_addr)
        A_INV: begin
          inv_r <= reg_wdata[NUM_DI-1:0];
          ainv_r <= reg_wdata[16 +: NAS];
        end
        A_DLY: dly_r <= reg_wdata[15:0];
        A_PAIR: pair_en_r <= reg_wdata[NUM_DI/2-1:0];
        A_TRAVEL: travel_r <= reg_wdata[15:0];
        A_FLUT: begin
          flut_win_r <= reg_wdata[7:0];
          flut_max_r <= reg_wdata[15:8];
        end
        A_CMODE: begin
          cmode_r <= reg_wdata[NUM_DI-1:0];
          tres_r <= reg_wdata[9:8];
        end
        A_CSYNC: begin
          csync_at_r <= {16'h0000, reg_wdata[15:0]};
          csync_iv_r <= reg_wdata[31:16];
        end
        A_AMODE: amode_r <= reg_wdata[NUM_AI-1:0];
        A_LIM1: lim1_r <= reg_wdata[VAL_W-1:0];
        A_LIM2: lim2_r <= reg_wdata[VAL_W-1:0];
        A_DELTA: delta_r <= reg_wdata[VAL_W-1:0];
        A_ACYC: acyc_r <= reg_wdata[15:0];
        A_TLIM1: tlim1_r <= reg_wdata[VAL_W-1:0];
        A_TLIM2: tlim2_r <= reg_wdata[VAL_W-1:0];
        A_TSYNC: tsync_iv_r <= reg_wdata[15:0];
        default: ;
      endcase
    end
  end

  // ************************************************************
  // one-second tick and real-time clock
  // ************************************************************
  logic [31:0] pre_r;
  logic tick;
  logic [15:0] tsync_cnt_r;

  assign tick = pre_r == 32'(TICK_CYC - 1);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pre_r <= '0;
      rtc_r <= '0;
    end else begin
      pre_r <= tick ? '0 : pre_r + 1'b1;
      if (ts_vld) begin
        rtc_r <= ts_time;
      end else if (reg_wr && reg_addr == A_RTC) begin
        rtc_r <= reg_wdata;
      end else if (tick) begin
        rtc_r <= rtc_r + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      tsync_cnt_r <= '0;
      ts_req <= 1'b0;
    end else begin
      ts_req <= 1'b0;
      if (tick && tsync_iv_r != '0) begin
        if (tsync_cnt_r + 1'b1 >= tsync_iv_r) begin
          tsync_cnt_r <= '0;
          ts_req <= 1'b1;
        end else begin
          tsync_cnt_r <= tsync_cnt_r + 1'b1;
        end
      end
    end
  end

  // ************************************************************
  // digital inputs
  // ************************************************************
  logic [NUM_DI-1:0] di_s;
  logic [NUM_DI-1:0] di_lvl;
  logic [NUM_DI-1:0] di_chg;
  logic [NUM_DI-1:0] di_mute;

  iecm_sync #(.W(NUM_DI)) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .d(di_pin),
    .q(di_s)
  );

  // ************************************************************
  // counters
  // ************************************************************
  logic [CNT_W-1:0] cnt_r [NUM_DI];
  logic [NUM_DI-1:0] crst_f_r;
  logic [NUM_DI-1:0] covf_f_r;
  logic [11:0] tdiv_r;
  logic ttick;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      tdiv_r <= '0;
    end else if (tick) begin
      tdiv_r <= ttick ? '0 : tdiv_r + 1'b1;
    end
  end

  always_comb begin
    unique case (tres_r)
      2'h1: ttick = tick && tdiv_r == 12'(MIN_SEC - 1);
      2'h2: ttick = tick && tdiv_r == 12'(HOUR_SEC - 1);
      default: ttick = tick;
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_DI; gi++) begin : g_di
      logic prev_s_r;
      logic inc;

      iecm_cond u_cond (
        .mclk(mclk),
        .nrst(nrst),
        .raw(di_s[gi]),
        .inv(inv_r[gi]),
        .dly(dly_r),
        .flut_win(flut_win_r),
        .flut_max(flut_max_r),
        .tick(tick),
        .lvl(di_lvl[gi]),
        .chg(di_chg[gi]),
        .muted(di_mute[gi])
      );

      assign inc = cmode_r[gi] ? (ttick && (di_s[gi] ^ inv_r[gi]))
                               : ((di_s[gi] ^ inv_r[gi]) && !prev_s_r);

      always_ff @(posedge mclk) begin
        if (!nrst) begin
          prev_s_r <= 1'b0;
          cnt_r[gi] <= '0;
          crst_f_r[gi] <= 1'b0;
          covf_f_r[gi] <= 1'b0;
        end else begin
          prev_s_r <= di_s[gi] ^ inv_r[gi];
          if (cmd_crst) begin
            cnt_r[gi] <= '0;
            crst_f_r[gi] <= 1'b1;
            covf_f_r[gi] <= 1'b0;
          end else if (inc) begin
            cnt_r[gi] <= cnt_r[gi] + 1'b1;
            if (cnt_r[gi] == '1) begin
              covf_f_r[gi] <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  // ************************************************************
  // double-point pairs
  // ************************************************************
  logic [15:0] trav_cnt_r [NUM_DI/2];
  iecm_pair_t pair_pos [NUM_DI/2];

  generate
    for (gi = 0; gi < NUM_DI / 2; gi++) begin : g_pair
      always_comb begin
        unique case (di_lvl[2*gi+1 -: 2])
          2'b01: pair_pos[gi] = PAIR_OPEN;
          2'b10: pair_pos[gi] = PAIR_CLOSED;
          2'b11: pair_pos[gi] = PAIR_FAULTPOS;
          default: pair_pos[gi] = PAIR_INTER;
        endcase
      end

      always_ff @(posedge mclk) begin
        if (!nrst) begin
          trav_cnt_r[gi] <= '0;
          pair_fault[gi] <= 1'b0;
        end else if (!pair_en_r[gi] || pair_pos[gi] != PAIR_INTER) begin
          trav_cnt_r[gi] <= '0;
          pair_fault[gi] <= 1'b0;
        end else if (tick) begin
          if (trav_cnt_r[gi] >= travel_r) begin
            pair_fault[gi] <= 1'b1;
          end else begin
            trav_cnt_r[gi] <= trav_cnt_r[gi] + 1'b1;
          end
        end
      end
    end
  endgenerate

  // ************************************************************
  // analog status: open, over, lim1, lim2, delta per channel
  // ************************************************************
  logic [VAL_W-1:0] aval_r [NUM_AI];
  logic [VAL_W-1:0] alast_r [NUM_AI];
  logic [NAS-1:0] araw_r;
  logic [NAS-1:0] a_chg;
  logic adelta_any;
  logic [NUM_AI-1:0] adelta;

  generate
    for (gi = 0; gi < NUM_AI; gi++) begin : g_ai
      logic [VAL_W-1:0] v;
      logic [VAL_W-1:0] diff;

      assign v = ai_val[gi*VAL_W +: VAL_W];
      assign diff = v > alast_r[gi] ? v - alast_r[gi] : alast_r[gi] - v;
      assign adelta[gi] = diff > delta_r;

      always_ff @(posedge mclk) begin
        if (!nrst) begin
          aval_r[gi] <= '0;
          araw_r[gi*4 +: 4] <= '0;
        end else if (ai_vld) begin
          aval_r[gi] <= v;
          araw_r[gi*4] <= v < (amode_r[gi] ? OPEN_V : OPEN_MA);
          araw_r[gi*4+1] <= v > (amode_r[gi] ? OVER_V : OVER_MA);
          araw_r[gi*4+2] <= v > lim1_r;
          araw_r[gi*4+3] <= v > lim2_r;
        end
      end
    end

    for (gi = 0; gi < NAS; gi++) begin : g_as
      iecm_cond u_acond (
        .mclk(mclk),
        .nrst(nrst),
        .raw(araw_r[gi]),
        .inv(ainv_r[gi]),
        .dly(dly_r),
        .flut_win(flut_win_r),
        .flut_max(8'h00),
        .tick(tick),
        .lvl(),
        .chg(a_chg[gi]),
        .muted()
      );
    end
  endgenerate

  assign adelta_any = ai_vld && |adelta;

  // ************************************************************
  // temperature checks
  // ************************************************************
  logic [NUM_TI-1:0] tstat_r;
  logic [NUM_TI-1:0] tnew;
  logic t_evt;

  generate
    for (gi = 0; gi < NUM_TI; gi++) begin : g_ti
      logic [VAL_W-1:0] tv;
      assign tv = t_val[gi*VAL_W +: VAL_W];
      assign tnew[gi] = tv > tlim1_r || tv > tlim2_r || t_fault[gi];
      always_ff @(posedge mclk) begin
        if (!nrst) begin
          tstat_r[gi] <= 1'b0;
        end else if (t_vld) begin
          tstat_r[gi] <= tnew[gi];
        end
      end
    end
  endgenerate

  assign t_evt = t_vld && tnew != tstat_r;

  // ************************************************************
  // cyclic timers and report trigger
  // ************************************************************
  logic [15:0] acyc_cnt_r;
  logic [15:0] ccyc_cnt_r;
  logic c_armed_r;
  logic a_cyc;
  logic c_cyc;
  logic [RC_W-1:0] cause_nxt;

  assign a_cyc = tick && acyc_r != '0 && acyc_cnt_r + 1'b1 >= acyc_r;
  assign c_cyc = tick && (c_armed_r ? (ccyc_cnt_r + 1'b1 >= csync_iv_r && csync_iv_r != '0)
                                    : rtc_r == csync_at_r);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      acyc_cnt_r <= '0;
      ccyc_cnt_r <= '0;
      c_armed_r <= 1'b0;
    end else if (tick) begin
      acyc_cnt_r <= a_cyc ? '0 : acyc_cnt_r + 1'b1;
      ccyc_cnt_r <= c_cyc ? '0 : ccyc_cnt_r + 1'b1;
      c_armed_r <= c_armed_r || c_cyc;
    end
  end

  always_comb begin
    cause_nxt = '0;
    cause_nxt[RC_DI] = |di_chg;
    cause_nxt[RC_CNT] = c_cyc || cmd_cgi;
    cause_nxt[RC_AI] = |a_chg || adelta_any || a_cyc;
    // temperature shares the analog cycle timer
    cause_nxt[RC_TI] = t_evt || a_cyc;
    cause_nxt[RC_GI] = cmd_gi;
    cause_nxt[RC_TSYNC] = ts_req;
  end

  // pending causes merge; a new cause beats the ack
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rpt_cause <= '0;
      rpt_req <= 1'b0;
      evt_stamp <= '0;
    end else begin
      rpt_cause <= (rpt_ack ? '0 : rpt_cause) | cause_nxt;
      rpt_req <= (rpt_req && !rpt_ack) || |cause_nxt;
      if (cause_nxt[RC_DI]) begin
        evt_stamp <= rtc_r;
      end
    end
  end

  // analog last-reported value refreshes on each analog report
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_AI; i++) begin
        alast_r[i] <= '0;
      end
    end else if (cause_nxt[RC_AI] || cmd_gi) begin
      for (int i = 0; i < NUM_AI; i++) begin
        alast_r[i] <= ai_vld ? ai_val[i*VAL_W +: VAL_W] : aval_r[i];
      end
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= '0;
      if (reg_addr >= A_CNT0 && reg_addr < A_CNT0 + 8'(4 * NUM_DI)) begin
        reg_rdata <= {6'h00, crst_f_r[reg_addr[4:2]], covf_f_r[reg_addr[4:2]],
                      cnt_r[reg_addr[4:2]]};
      end else if (reg_addr >= A_AST0 && reg_addr < A_AST0 + 8'(4 * NUM_AI)) begin
        reg_rdata <= {12'h000, araw_r[reg_addr[3:2]*4 +: 4], aval_r[reg_addr[3:2]]};
      end else begin
        unique case (reg_addr)
          A_INV: reg_rdata <= {ainv_r, 10'h000, inv_r};
          A_DLY: reg_rdata <= {16'h0000, dly_r};
          A_RTC: reg_rdata <= rtc_r;
          A_STAT: reg_rdata <= {12'h000, tstat_r, 1'b0, pair_fault, di_mute, di_lvl};
          default: reg_rdata <= '0;
        endcase
      end
    end
  end
endmodule : iecm_top

// ---- common/iecm_pkg.sv ----
// iecm_pkg: shared constants for the input event counter monitor
// assumes a 250 MHz mclk and a plain register port in the top module
package iecm_pkg;
  // ************************************************************
  // sizes
  // ************************************************************
  localparam int NUM_DI = 6;
  localparam int NUM_AI = 4;
  localparam int NUM_TI = 4;
  localparam int CNT_W = 24;
  localparam int VAL_W = 16;
  localparam int RTC_W = 32;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_MHZ = 250;
  localparam int SEC_US = 1000000;
  localparam int SEC_CYC = CLK_MHZ * SEC_US;
  localparam int MIN_SEC = 60;
  localparam int HOUR_SEC = 3600;

  // ************************************************************
  // register offsets (byte addresses, 32-bit words)
  // ************************************************************
  localparam logic [7:0] A_INV = 8'h00;
  localparam logic [7:0] A_DLY = 8'h04;
  localparam logic [7:0] A_PAIR = 8'h08;
  localparam logic [7:0] A_TRAVEL = 8'h0c;
  localparam logic [7:0] A_FLUT = 8'h10;
  localparam logic [7:0] A_CMODE = 8'h14;
  localparam logic [7:0] A_CSYNC = 8'h18;
  localparam logic [7:0] A_CMD = 8'h1c;
  localparam logic [7:0] A_AMODE = 8'h20;
  localparam logic [7:0] A_LIM1 = 8'h24;
  localparam logic [7:0] A_LIM2 = 8'h28;
  localparam logic [7:0] A_DELTA = 8'h2c;
  localparam logic [7:0] A_ACYC = 8'h30;
  localparam logic [7:0] A_TLIM1 = 8'h34;
  localparam logic [7:0] A_TLIM2 = 8'h38;
  localparam logic [7:0] A_TSYNC = 8'h3c;
  localparam logic [7:0] A_RTC = 8'h40;
  localparam logic [7:0] A_STAT = 8'h44;
  localparam logic [7:0] A_CNT0 = 8'h80;
  localparam logic [7:0] A_AST0 = 8'hc0;

  // ************************************************************
  // command bits (A_CMD)
  // ************************************************************
  localparam int CMD_CGI = 0;
  localparam int CMD_GI = 1;
  localparam int CMD_CRST = 2;
  localparam int CMD_ACK = 3;

  // ************************************************************
  // analog thresholds in raw adc units (current mode, voltage mode)
  // ************************************************************
  localparam logic [VAL_W-1:0] OPEN_MA = 16'h0fa0;
  localparam logic [VAL_W-1:0] OVER_MA = 16'h55f0;
  localparam logic [VAL_W-1:0] OPEN_V = 16'h07d0;
  localparam logic [VAL_W-1:0] OVER_V = 16'h2af8;

  // ************************************************************
  // report cause bits
  // ************************************************************
  localparam int RC_DI = 0;
  localparam int RC_CNT = 1;
  localparam int RC_AI = 2;
  localparam int RC_TI = 3;
  localparam int RC_GI = 4;
  localparam int RC_TSYNC = 5;
  localparam int RC_W = 6;

  typedef enum logic [1:0] {PAIR_INTER, PAIR_OPEN, PAIR_CLOSED, PAIR_FAULTPOS} iecm_pair_t;
endpackage : iecm_pkg

// ---- design/iecm_sync.sv ----
// iecm_sync: two-stage synchroniser for a vector of field inputs
// assumes inputs may change at any time relative to mclk
`timescale 1ns/10ps
module iecm_sync #(
  parameter int W = 6
) (
  mclk,
  nrst,
  d,
  q
);
  input wire logic mclk;
  input wire logic nrst;
  input wire logic [W-1:0] d;
  output logic [W-1:0] q;

  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : iecm_sync

// ---- design/iecm_cond.sv ----
// iecm_cond: inversion, send delay and deflutter for one status bit
// assumes a synchronised input and a one-cycle time-base tick
`timescale 1ns/10ps
module iecm_cond #(
  parameter int DW = 16,
  parameter int FW = 8
) (
  mclk,
  nrst,
  raw,
  inv,
  dly,
  flut_win,
  flut_max,
  tick,
  lvl,
  chg,
  muted
);
  input wire logic mclk;
  input wire logic nrst;
  input wire logic raw;
  input wire logic inv;
  input wire logic [DW-1:0] dly;
  input wire logic [FW-1:0] flut_win;
  input wire logic [FW-1:0] flut_max;
  input wire logic tick;
  output logic lvl;
  output logic chg;
  output logic muted;

  logic cur;
  logic prev_r;
  logic [DW-1:0] dcnt_r;
  logic pend_r;
  logic [FW-1:0] wcnt_r;
  logic [FW-1:0] ecnt_r;
  logic edge_s;

  assign cur = raw ^ inv;
  assign edge_s = cur != prev_r;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= cur;
    end
  end

  // ************************************************************
  // send delay: level must hold for dly ticks before it reports
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      dcnt_r <= '0;
      pend_r <= 1'b0;
      lvl <= 1'b0;
      chg <= 1'b0;
    end else begin
      chg <= 1'b0;
      if (edge_s) begin
        dcnt_r <= dly;
        pend_r <= cur != lvl;
      end else if (pend_r && dcnt_r == '0) begin
        pend_r <= 1'b0;
        lvl <= cur;
        chg <= !muted;
      end else if (pend_r && tick) begin
        dcnt_r <= dcnt_r - 1'b1;
      end
    end
  end

  // ************************************************************
  // deflutter: too many edges in one window mutes the input
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wcnt_r <= '0;
      ecnt_r <= '0;
      muted <= 1'b0;
    end else if (tick && wcnt_r >= flut_win) begin
      // an edge on the closing tick still counts, set beats the window end
      wcnt_r <= '0;
      ecnt_r <= FW'(edge_s);
      muted <= (ecnt_r > flut_max || (edge_s && ecnt_r >= flut_max))
               && (flut_max != '0);
    end else begin
      if (tick) begin
        wcnt_r <= wcnt_r + 1'b1;
      end
      if (edge_s && ecnt_r != '1) begin
        ecnt_r <= ecnt_r + 1'b1;
      end
      if (edge_s && ecnt_r >= flut_max && flut_max != '0) begin
        muted <= 1'b1;
      end
    end
  end
endmodule : iecm_cond

// ---- tb/iecm_field_model.sv ----
// iecm_field_model: contacts and sensor front ends beside iecm_top
// assumes the bench sets contact levels and raw samples after an edge
`timescale 1ns/10ps
module iecm_field_model
  import iecm_pkg::*;
(
  mclk,
  di_set,
  ai_set,
  di_pin,
  ai_val,
  ai_vld,
  t_vld
);
  input wire logic mclk;
  input wire logic [NUM_DI-1:0] di_set;
  input wire logic [NUM_AI*VAL_W-1:0] ai_set;
  output logic [NUM_DI-1:0] di_pin = 6'h00;
  output logic [NUM_AI*VAL_W-1:0] ai_val = '0;
  output logic ai_vld = 1'b0;
  output logic t_vld = 1'b0;
  logic [3:0] ph_r = 4'h0;
  // adc bus shows junk outside the strobe, so stale values cannot pass
  always @(posedge mclk) begin
    di_pin <= di_set;
    ph_r <= ph_r + 4'h1;
    ai_vld <= (ph_r == 4'hf);
    t_vld <= (ph_r == 4'h7);
    ai_val <= (ph_r == 4'hf) ? ai_set : ~ai_set;
  end
endmodule : iecm_field_model

// ---- tb/iecm_top_properties.sv ----
// iecm_top_properties: port checks of report and register paths
// assumes it is bound into every iecm_top
`timescale 1ns/10ps
module iecm_top_properties
  import iecm_pkg::*;
(
  mclk,
  nrst,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  rpt_ack,
  rpt_req,
  rpt_cause,
  ts_req
);
  input wire logic mclk;
  input wire logic nrst;
  input wire logic [7:0] reg_addr;
  input wire logic [31:0] reg_wdata;
  input wire logic reg_wr;
  input wire logic reg_rd;
  input wire logic [31:0] reg_rdata;
  input wire logic rpt_ack;
  input wire logic rpt_req;
  input wire logic [RC_W-1:0] rpt_cause;
  input wire logic ts_req;
  wire logic wcmd = reg_wr && reg_addr == A_CMD;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  chk_req_pending: assert property (rpt_req && !rpt_ack |=> rpt_req)
    else $error("report dropped without ack");
  chk_cause_kept: assert property (rpt_req && !rpt_ack |=>
    (rpt_cause & $past(rpt_cause)) == $past(rpt_cause)) else $error("cause lost");
  chk_req_cause: assert property (rpt_req |-> rpt_cause != '0)
    else $error("report without cause");
  chk_gi_queue: assert property (wcmd && reg_wdata[CMD_GI] |=> rpt_req && rpt_cause[RC_GI])
    else $error("interrogation not queued");
  chk_cgi_queue: assert property (wcmd && reg_wdata[CMD_CGI] |=> rpt_cause[RC_CNT])
    else $error("counter interrogation not queued");
  chk_sync_pulse: assert property (ts_req |=> !ts_req)
    else $error("sync request too long");
  chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  chk_unmapped_zero: assert property (reg_rd && reg_addr == 8'hfc |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
endmodule : iecm_top_properties
bind iecm_top iecm_top_properties u_chk (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rpt_ack(rpt_ack), .rpt_req(rpt_req), .rpt_cause(rpt_cause), .ts_req(ts_req));

// ---- tb/tb_top.sv ----
// tb_top: self-checking bench for iecm_top, 8-cycle second
// assumes one 250 MHz clock and the field model on the contact side
`timescale 1ns/10ps
module tb_top;
  import iecm_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic rpt_ack = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, v;
  logic [NUM_DI-1:0] di_set = 6'h00, di_pin;
  logic [NUM_AI*VAL_W-1:0] ai_set = 64'h1f40_1f40_1f40_1f40, ai_val;
  logic ai_vld, t_vld, rpt_req, ts_req;
  logic ts_vld = 1'b0;
  logic [31:0] ts_time = 32'h0;
  int n_fail = 0;
  int cmp_count = 0;
  initial forever #2 mclk = ~mclk;
  iecm_field_model u_fld (.mclk(mclk), .di_set(di_set), .ai_set(ai_set), .di_pin(di_pin),
    .ai_val(ai_val), .ai_vld(ai_vld), .t_vld(t_vld));
  iecm_top #(.TICK_CYC(8)) u_dut (.mclk(mclk), .nrst(nrst), .di_pin(di_pin),
    .ai_val(ai_val), .ai_vld(ai_vld), .t_val(64'h0), .t_fault(4'h0), .t_vld(t_vld),
    .ts_time(ts_time), .ts_vld(ts_vld), .rpt_ack(rpt_ack), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(),
    .rpt_req(rpt_req), .rpt_cause(), .evt_stamp(), .ts_req(ts_req), .pair_fault());
  // ********
  // tasks
  // ********
  task automatic end_sim();
    $display("checks %0d errors %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr
  // data loads at the strobe edge and holds until the next read: taken one edge later
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    v = u_dut.reg_rdata;
  endtask : rd
  task automatic ack();
    rpt_ack <= 1'b1;
    @(posedge mclk);
    rpt_ack <= 1'b0;
    @(posedge mclk);
  endtask : ack
  task automatic t_gi();
    wr(A_CMD, 32'h1 << CMD_GI);
    @(posedge mclk);
    cmp("gi req", 32'h3, {30'h0, rpt_req, u_dut.rpt_cause[RC_GI]});
    repeat (5) @(posedge mclk);
    cmp("held", 32'h1, {31'h0, rpt_req});
    ack();
    cmp("acked", 32'h0, {31'h0, rpt_req});
  endtask : t_gi
  task automatic t_inv();
    wr(A_INV, 32'h2);
    repeat (8) @(posedge mclk);
    rd(A_STAT);
    cmp("stat", 32'h2, {20'h0, v[11:0]});
  endtask : t_inv
  task automatic t_cnt();
    repeat (5) begin
      di_set[0] <= 1'b1;
      repeat (4) @(posedge mclk);
      di_set[0] <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    repeat (8) @(posedge mclk);
    rd(A_CNT0);
    cmp("count", 32'h5, v);
    wr(A_CMD, 32'h1 << CMD_CRST);
    rd(A_CNT0);
    cmp("cleared", 32'h0200_0000, v);
  endtask : t_cnt
  task automatic t_ana(input logic [15:0] s, input logic [3:0] st);
    ai_set[15:0] <= s;
    repeat (40) @(posedge mclk);
    rd(A_AST0);
    cmp("analog", {12'h0, st, s}, {12'h0, v[19:0]});
  endtask : t_ana
  // stamp may see one tick between time load and event
  task automatic t_pair();
    wr(A_TRAVEL, 32'h2);
    wr(A_PAIR, 32'h1);
    ts_time <= 32'h1000;
    ts_vld <= 1'b1;
    @(posedge mclk);
    ts_vld <= 1'b0;
    wr(A_INV, 32'h0);
    repeat (40) @(posedge mclk);
    cmp("stamp", 32'h800, {1'b0, u_dut.evt_stamp[31:1]});
    cmp("pair fault", 32'h1, {31'h0, u_dut.pair_fault[0]});
    wr(A_INV, 32'h2);
    repeat (4) @(posedge mclk);
    cmp("pair closed", 32'h0, {31'h0, u_dut.pair_fault[0]});
  endtask : t_pair
  task automatic t_flut();
    wr(A_FLUT, 32'h020a);
    repeat (6) begin
      di_set[2] <= ~di_set[2];
      repeat (4) @(posedge mclk);
    end
    rd(A_STAT);
    cmp("muted", 32'h1, {31'h0, v[8]});
  endtask : t_flut
  task automatic t_tsync();
    int n;
    n = 0;
    wr(A_TSYNC, 32'h1);
    repeat (8) @(posedge mclk);
    repeat (16) begin
      @(posedge mclk);
      n += ts_req;
    end
    cmp("ts pulses", 32'h2, n);
  endtask : t_tsync
  // ********
  // sequence
  // ********
  initial begin
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    wr(A_TSYNC, 32'h0);
    wr(A_CSYNC, 32'h0);
    wr(A_LIM1, 32'hffff);
    wr(A_LIM2, 32'hffff);
    wr(A_DELTA, 32'hffff);
    repeat (40) @(posedge mclk);
    ack();
    t_gi();
    wr(A_CMD, 32'h1 << CMD_CGI);
    t_inv();
    t_cnt();
    t_ana(16'h0100, 4'h1);
    t_ana(16'h6000, 4'h2);
    rd(8'hfc);
    cmp("unmapped", 32'h0, v);
    t_pair();
    t_flut();
    t_tsync();
    end_sim();
  end
  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    end_sim();
  end
endmodule : tb_top
